// *** shared/lcd_defs.vh ***
// lcd_defs.vh: constants for the command decoder
// assumes inclusion by bare name from design files
`ifndef LCD_DEFS_VH
`define LCD_DEFS_VH
// power states
`define LCD_ST_IDLE      3'h0
`define LCD_ST_ACTIVE    3'h1
`define LCD_ST_IDLE_PD   3'h2
`define LCD_ST_ACT_PD    3'h3
`define LCD_ST_RST_PD    3'h4
`define LCD_ST_SELF_REFRESH_STATE      3'h5
`define LCD_ST_DPD       3'h6
`define LCD_ST_RESETTING 3'h7
// decoded command codes
`define LCD_CMD_NOP      4'h0
`define LCD_CMD_MRW      4'h1
`define LCD_CMD_MRR      4'h2
`define LCD_CMD_REFPB    4'h3
`define LCD_CMD_REFAB    4'h4
`define LCD_CMD_ACT      4'h5
`define LCD_CMD_WR       4'h6
`define LCD_CMD_RD       4'h7
`define LCD_CMD_PRE      4'h8
`define LCD_CMD_PD_IN    4'h9
`define LCD_CMD_SELF_REFRESH_STATE_IN  4'hA
`define LCD_CMD_DPD_IN   4'hB
`define LCD_CMD_PD_OUT   4'hC
`define LCD_CMD_INVALID  4'hF
// bank count and bank-open reset value
`define LCD_BANKS        8
`define LCD_BANK_RST     8'h00
`endif

// *** hw/lcd_cke_sync.v ***
// lcd_cke_sync.v: holds previous-edge clock enable; current level passed straight through
// assumes cke is a synchronous input; exit reported as soon as cke rises
module lcd_cke_sync (
  // clock and reset
  input  wire i_clk,
  input  wire i_rst_n,
  // clock enable pin
  input  wire i_cke,
  // pair of samples
  output reg  o_cke_prev,
  output wire o_cke_cur
);
  always @(posedge i_clk)
  begin
    if (!i_rst_n)
      o_cke_prev <= 1'b0;
    else
      o_cke_prev <= i_cke;
  end
  assign o_cke_cur = i_cke;
endmodule

// *** hw/lcd_bank_table.v ***
// lcd_bank_table.v: open/closed flag per bank
// assumes one operation per cycle from the decoder
`include "lcd_defs.vh"
module lcd_bank_table (
  // clock and reset
  input  wire       i_clk,
  input  wire       i_rst_n,
  // operations
  input  wire       i_open,
  input  wire       i_close,
  input  wire       i_close_all,
  input  wire       i_clear,
  input  wire [2:0] i_bank,
  input  wire [2:0] i_close_bank,
  input  wire       i_close2,
  // state
  output reg  [7:0] o_open
);
  genvar g;
  generate
    for (g = 0; g < `LCD_BANKS; g = g + 1)
    begin : g_bank
      always @(posedge i_clk)
      begin
        if (!i_rst_n || i_clear)
          o_open[g] <= 1'b0;
        else if (i_close_all)
          o_open[g] <= 1'b0;
        else if (i_open && i_bank == g)
          o_open[g] <= 1'b1;
        else if ((i_close && i_bank == g) || (i_close2 && i_close_bank == g))
          o_open[g] <= 1'b0;
      end
    end
  endgenerate
endmodule

// *** hw/lcd_cmd_decode.v ***
// lcd_cmd_decode.v: command decoder for a low-power ddr sdram die
// assumes all inputs synchronous to I_CLK; falling-edge bits given
// already captured as I_CA_FALL alongside I_CA_RISE
//
// Functional notes
// - command from cs, ca0-3, cke and the low-power state only
// - cs and cke sampled rising; cke pair
// - ca captured rising and falling halves
// - mode write: address and operand fields
// - activate: row and bank field split
// - column bit zero forced low
// - auto precharge closes bank after access
// - all-bank precharge ignores bank field
// - bank commands other than all-bank precharge touch addressed bank only
// - with cke high on both edges, cs high or ca0-2 high is nop
// - ca ignored during low-power states; cs only gates power-down exit
// - self refresh/deep exits by cke alone
// - cke low-low keeps low-power state
// - cke rise with cs high exits active/idle power-down to active/idle
// - resetting exit goes idle if init done
`include "lcd_defs.vh"
module lcd_cmd_decode (
  // clock and reset
  input  wire        I_CLK,
  input  wire        I_RST_N,
  // command pins
  input  wire        I_CKE,
  input  wire        I_CS_N,
  input  wire [9:0]  I_CA_RISE,
  input  wire [9:0]  I_CA_FALL,
  // device context
  input  wire        i_resetting,
  input  wire        i_init_done,
  // decoded command
  output reg  [3:0]  O_CMD,
  output reg         O_CMD_VALID,
  output reg  [7:0]  O_MR_ADDR,
  output reg  [7:0]  O_MR_OPERAND,
  output reg  [14:0] O_ROW,
  output reg  [11:0] O_COL,
  output reg  [2:0]  O_BANK,
  output reg         O_AUTO_PRECHARGE_FLAG,
  output reg         O_ALL_BANK_FLAG,
  // state
  output reg  [2:0]  O_POWER_STATE,
  output reg  [7:0]  O_BANK_OPEN
);
  wire       cke_prev;
  wire       cke_cur;
  wire [7:0] bank_open;
  reg  [2:0] state_reg;
  reg  [2:0] state_next;
  reg  [3:0] cmd_next;
  wire [9:0] r = I_CA_RISE;
  wire [9:0] f = I_CA_FALL;
  wire       any_open = |bank_open;
  wire       low_power = (state_reg == `LCD_ST_IDLE_PD) || (state_reg == `LCD_ST_ACT_PD) ||
                         (state_reg == `LCD_ST_RST_PD) || (state_reg == `LCD_ST_SELF_REFRESH_STATE) ||
                         (state_reg == `LCD_ST_DPD);

  lcd_cke_sync u_cke (
    .i_clk      (I_CLK),
    .i_rst_n    (I_RST_N),
    .i_cke      (I_CKE),
    .o_cke_prev (cke_prev),
    .o_cke_cur  (cke_cur)
  );

  // command decode from cs, ca0-3, the cke pair and the low-power state only
  always @*
  begin
    cmd_next = `LCD_CMD_INVALID;
    if (low_power)
    begin
      if (!cke_prev && cke_cur)
        cmd_next = `LCD_CMD_PD_OUT;
      else
        cmd_next = `LCD_CMD_NOP;
    end
    else if (cke_prev && !cke_cur)
    begin
      if (I_CS_N)
        cmd_next = `LCD_CMD_PD_IN;
      else if (r[2:0] == 3'h4)
        cmd_next = `LCD_CMD_SELF_REFRESH_STATE_IN;
      else if (r[2:0] == 3'h3)
        cmd_next = `LCD_CMD_DPD_IN;
    end
    else if (cke_prev && cke_cur)
    begin
      if (I_CS_N || r[2:0] == 3'h7)
        cmd_next = `LCD_CMD_NOP;
      else if (r[1:0] == 2'h2)
        cmd_next = `LCD_CMD_ACT;
      else if (r[1:0] == 2'h1)
        cmd_next = r[2] ? `LCD_CMD_RD : `LCD_CMD_WR;
      else if (r[3:0] == 4'hB)
        cmd_next = `LCD_CMD_PRE;
      else if (r[3:0] == 4'h0)
        cmd_next = `LCD_CMD_MRW;
      else if (r[3:0] == 4'h8)
        cmd_next = `LCD_CMD_MRR;
      else if (r[3:0] == 4'h4)
        cmd_next = `LCD_CMD_REFPB;
      else if (r[3:0] == 4'hC)
        cmd_next = `LCD_CMD_REFAB;
    end
  end

  // power state machine
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      `LCD_ST_IDLE, `LCD_ST_ACTIVE, `LCD_ST_RESETTING:
      begin
        if (cmd_next == `LCD_CMD_PD_IN)
        begin
          if (state_reg == `LCD_ST_RESETTING)
            state_next = `LCD_ST_RST_PD;
          else if (any_open)
            state_next = `LCD_ST_ACT_PD;
          else
            state_next = `LCD_ST_IDLE_PD;
        end
        else if (cmd_next == `LCD_CMD_SELF_REFRESH_STATE_IN)
          state_next = `LCD_ST_SELF_REFRESH_STATE;
        else if (cmd_next == `LCD_CMD_DPD_IN)
          state_next = `LCD_ST_DPD;
        else if (state_reg == `LCD_ST_RESETTING)
          state_next = i_init_done ? `LCD_ST_IDLE : `LCD_ST_RESETTING;
        else if (i_resetting)
          state_next = `LCD_ST_RESETTING;
        else if (cmd_next == `LCD_CMD_ACT)
          state_next = `LCD_ST_ACTIVE;
        else if (cmd_next == `LCD_CMD_PRE && (r[4] || bank_open == (8'h01 << r[9:7])))
          state_next = `LCD_ST_IDLE;
      end
      `LCD_ST_ACT_PD:
        if (cmd_next == `LCD_CMD_PD_OUT && I_CS_N)
          state_next = `LCD_ST_ACTIVE;
      `LCD_ST_IDLE_PD:
        if (cmd_next == `LCD_CMD_PD_OUT && I_CS_N)
          state_next = `LCD_ST_IDLE;
      `LCD_ST_RST_PD:
        if (cmd_next == `LCD_CMD_PD_OUT && I_CS_N)
          state_next = i_init_done ? `LCD_ST_IDLE : `LCD_ST_RESETTING;
      `LCD_ST_SELF_REFRESH_STATE:
        if (cmd_next == `LCD_CMD_PD_OUT)
          state_next = `LCD_ST_IDLE;
      `LCD_ST_DPD:
        if (cmd_next == `LCD_CMD_PD_OUT)
          state_next = `LCD_ST_RESETTING; // device must be reinitialised
      default:
        state_next = `LCD_ST_IDLE;
    endcase
  end

  always @(posedge I_CLK)
  begin
    if (!I_RST_N)
      state_reg <= `LCD_ST_IDLE;
    else
      state_reg <= state_next;
  end

  // bank bookkeeping; a read/write with auto precharge closes its bank
  lcd_bank_table u_banks (
    .i_clk        (I_CLK),
    .i_rst_n      (I_RST_N),
    .i_open       (cmd_next == `LCD_CMD_ACT),
    .i_close      (cmd_next == `LCD_CMD_PRE && !r[4]),
    .i_close_all  (cmd_next == `LCD_CMD_PRE && r[4]),
    .i_clear      (cmd_next == `LCD_CMD_DPD_IN),
    .i_bank       (r[9:7]),
    .i_close_bank (r[9:7]),
    .i_close2     ((cmd_next == `LCD_CMD_RD || cmd_next == `LCD_CMD_WR) && f[0]),
    .o_open       (bank_open)
  );

  // registered outputs with fields split per half-cycle
  always @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      O_CMD                 <= `LCD_CMD_NOP;
      O_CMD_VALID           <= 1'b0;
      O_MR_ADDR             <= 8'h00;
      O_MR_OPERAND          <= 8'h00;
      O_ROW                 <= 15'h0000;
      O_COL                 <= 12'h000;
      O_BANK                <= 3'h0;
      O_AUTO_PRECHARGE_FLAG <= 1'b0;
      O_ALL_BANK_FLAG       <= 1'b0;
      O_POWER_STATE         <= `LCD_ST_IDLE;
      O_BANK_OPEN           <= `LCD_BANK_RST;
    end
    else
    begin
      O_CMD         <= cmd_next;
      // undefined encodings and nops produce no valid command
      O_CMD_VALID   <= (cmd_next != `LCD_CMD_NOP) && (cmd_next != `LCD_CMD_INVALID);
      O_POWER_STATE <= state_next;
      O_BANK_OPEN   <= bank_open;
      case (cmd_next)
        `LCD_CMD_MRW, `LCD_CMD_MRR:
        begin
          O_MR_ADDR <= {f[1:0], r[9:4]};
          if (cmd_next == `LCD_CMD_MRW)
            O_MR_OPERAND <= f[9:2];
        end
        `LCD_CMD_ACT:
        begin
          O_ROW  <= {f[9:8], r[6:2], f[7:0]};
          O_BANK <= r[9:7];
        end
        `LCD_CMD_RD, `LCD_CMD_WR:
        begin
          O_COL                 <= {f[9:1], r[6:5], 1'b0};
          O_BANK                <= r[9:7];
          O_AUTO_PRECHARGE_FLAG <= f[0];
        end
        `LCD_CMD_PRE:
        begin
          O_BANK          <= r[9:7];
          O_ALL_BANK_FLAG <= r[4];
        end
        default:
          O_ALL_BANK_FLAG <= O_ALL_BANK_FLAG;
      endcase
    end
  end
endmodule

// *** testbench/lcd_ctrl_model.sv ***
// lcd_ctrl_model.sv: controller side driving cke, cs and ca halves
// assumes the bench calls send once per cycle from its main process
module lcd_ctrl_model (
  input  wire       i_clk,
  output reg        o_cke,
  output reg        o_cs_n,
  output reg  [9:0] o_ca_rise,
  output reg  [9:0] o_ca_fall
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    o_cke = 1'b1;
    o_cs_n = 1'b1;
    o_ca_rise = 10'h000;
    o_ca_fall = 10'h000;
  end
  // commands are legal sequences except one undefined encoding; exits followed by nops
  task automatic send(input logic c, input logic s, input logic [9:0] r, input logic [9:0] f);
    logic lp;
    @(posedge i_clk);
    lp = !c && !o_cke;
    o_cke <= c;
    // cs floats in low power, shown as a toggling level
    o_cs_n <= lp ? ~o_cs_n : s;
    // unselected or low-power bus floats; selected bits defined otherwise
    o_ca_rise <= (s || lp) ? ~o_ca_rise : r;
    o_ca_fall <= (s || lp) ? ~o_ca_fall : f;
  endtask
endmodule

// *** testbench/lcd_cmd_monitor.sv ***
// lcd_cmd_monitor.sv: concurrent checks on the decoder pins
// assumes bind to lcd_cmd_decode; fields appear one cycle after taking
module lcd_cmd_monitor (
  input wire        I_CLK,
  input wire        I_RST_N,
  input wire        I_CKE,
  input wire        I_CS_N,
  input wire [9:0]  I_CA_RISE,
  input wire [9:0]  I_CA_FALL,
  input wire [3:0]  O_CMD,
  input wire        O_CMD_VALID,
  input wire [7:0]  O_MR_ADDR,
  input wire [7:0]  O_MR_OPERAND,
  input wire [14:0] O_ROW,
  input wire [11:0] O_COL,
  input wire [2:0]  O_BANK,
  input wire        O_AUTO_PRECHARGE_FLAG,
  input wire        O_ALL_BANK_FLAG,
  input wire [2:0]  O_POWER_STATE,
  input wire [7:0]  O_BANK_OPEN
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] r_q;
  logic [9:0] f_q;
  always @(posedge I_CLK)
  begin
    r_q <= I_CA_RISE;
    f_q <= I_CA_FALL;
  end
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  // $past of reset keeps the first edge out, where cke history is stale
  sequence awake;
    I_CKE && $past(I_CKE) && $past(I_RST_N) && !(O_POWER_STATE inside {[3'h2:3'h6]});
  endsequence
  sequence sel;
    awake ##0 !I_CS_N;
  endsequence
  chk_nop_cs: assert property (awake ##0 I_CS_N |=> O_CMD == 4'h0 && !O_CMD_VALID)
    else $error("cs high not nop");
  chk_mrw_fields: assert property (sel ##0 I_CA_RISE[3:0] == 4'h0 |=>
    O_CMD == 4'h1 && O_MR_ADDR == {f_q[1:0], r_q[9:4]} && O_MR_OPERAND == f_q[9:2])
    else $error("mode write fields wrong");
  chk_act_fields: assert property (sel ##0 I_CA_RISE[1:0] == 2'b10 |=> O_CMD == 4'h5 &&
    O_ROW == {f_q[9:8], r_q[6:2], f_q[7:0]} && O_BANK == r_q[9:7])
    else $error("activate fields wrong");
  chk_rdwr_col: assert property (sel ##0 I_CA_RISE[1:0] == 2'b01 |=>
    O_CMD == (r_q[2] ? 4'h7 : 4'h6) && O_COL == {f_q[9:1], r_q[6:5], 1'b0}
    && O_AUTO_PRECHARGE_FLAG == f_q[0]) else $error("read/write fields wrong");
  chk_all_bank: assert property (sel ##0 I_CA_RISE[4:0] == 5'h1B |=>
    O_CMD == 4'h8 && O_ALL_BANK_FLAG ##1 O_BANK_OPEN == 8'h00)
    else $error("all-bank precharge left banks open");
  chk_undef_code: assert property (sel ##0 I_CA_RISE[3:0] == 4'h3 |=>
    O_CMD == 4'hF && !O_CMD_VALID ##1 $stable(O_BANK_OPEN)) else $error("undefined code acted");
  chk_lp_hold: assert property (!I_CKE && !$past(I_CKE) && O_POWER_STATE inside {[3'h2:3'h6]}
    |=> $stable(O_POWER_STATE) && !O_CMD_VALID) else $error("low-power state left");
  chk_pd_entry: assert property ($past(I_CKE) && !I_CKE && I_CS_N && $past(I_RST_N) &&
    O_POWER_STATE <= 3'h1 |=> O_POWER_STATE == $past(O_POWER_STATE) + 3'h2)
    else $error("power-down entry wrong");
  chk_pd_exit: assert property (!$past(I_CKE) && I_CKE && I_CS_N &&
    O_POWER_STATE inside {3'h2, 3'h3} |=> O_POWER_STATE == $past(O_POWER_STATE) - 3'h2)
    else $error("power-down exit wrong");
endmodule

// *** testbench/lcd_cmd_decode_test.sv ***
// lcd_cmd_decode_test.sv: directed command and power-state tests
// assumes lcd_ctrl_model drives the pins; checker bound at the foot
module lcd_cmd_decode_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        I_CLK;
  logic        I_RST_N;
  logic        i_resetting;
  logic        i_init_done;
  wire         I_CKE, I_CS_N, O_CMD_VALID, O_AUTO_PRECHARGE_FLAG, O_ALL_BANK_FLAG;
  wire  [9:0]  I_CA_RISE, I_CA_FALL;
  wire  [3:0]  O_CMD;
  wire  [7:0]  O_MR_ADDR, O_MR_OPERAND, O_BANK_OPEN;
  wire  [14:0] O_ROW;
  wire  [11:0] O_COL;
  wire  [2:0]  O_BANK, O_POWER_STATE;
  int          error_cnt;
  int          total_checks;
  logic [9:0]  tbl_r [4] = '{10'h3F4, 10'h00C, 10'h007, 10'h3C3};
  logic [3:0]  tbl_c [4] = '{4'h3, 4'h4, 4'h0, 4'hF};
  lcd_cmd_decode dut_u (.*);
  lcd_ctrl_model ctl_u (.i_clk(I_CLK), .o_cke(I_CKE), .o_cs_n(I_CS_N),
    .o_ca_rise(I_CA_RISE), .o_ca_fall(I_CA_FALL));
  initial
  begin
    I_CLK = 1'b0;
    forever #4 I_CLK = ~I_CLK;
  end
  task automatic chk(input string n, input logic [14:0] e, input logic [14:0] g);
    total_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  task automatic nop(input logic c, input int n);
    repeat (n) ctl_u.send(c, 1'b1, 10'h000, 10'h000);
    #1;
  endtask
  task automatic op(input logic c, input logic s, input logic [9:0] r, input logic [9:0] f);
    ctl_u.send(c, s, r, f);
    nop(c, 1);
  endtask
  task automatic report_and_stop;
    $display("checks %0d, errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    I_RST_N = 1'b0;
    i_resetting = 1'b0;
    i_init_done = 1'b0;
    repeat (8) @(posedge I_CLK);
    I_RST_N <= 1'b1;
    nop(1'b1, 2);
    chk("state", 3'h0, O_POWER_STATE);
    chk("open", 8'h00, O_BANK_OPEN);
    op(1'b1, 1'b0, 10'h3F0, 10'h296);
    chk("cmd", 4'h1, O_CMD);
    chk("mr_addr", 8'hBF, O_MR_ADDR);
    chk("operand", 8'hA5, O_MR_OPERAND);
    chk("valid", 1'b1, O_CMD_VALID);
    op(1'b1, 1'b0, 10'h158, 10'h3FD);
    chk("cmd", 4'h2, O_CMD);
    chk("mr_addr", 8'h55, O_MR_ADDR);
    op(1'b1, 1'b0, 10'h2EE, 10'h23C);
    chk("row", 15'h5B3C, O_ROW);
    chk("bank", 3'h5, O_BANK);
    nop(1'b1, 1);
    chk("open", 8'h20, O_BANK_OPEN);
    op(1'b1, 1'b0, 10'h2F9, 10'h356);
    chk("cmd", 4'h6, O_CMD);
    chk("col", 12'hD5E, O_COL);
    op(1'b1, 1'b0, 10'h2FD, 10'h357);
    chk("cmd", 4'h7, O_CMD);
    chk("ap", 1'b1, O_AUTO_PRECHARGE_FLAG);
    nop(1'b1, 3);
    chk("open", 8'h00, O_BANK_OPEN);
    op(1'b1, 1'b0, 10'h082, 10'h000);
    op(1'b1, 1'b0, 10'h102, 10'h000);
    op(1'b1, 1'b0, 10'h08B, 10'h000);
    chk("ab", 1'b0, O_ALL_BANK_FLAG);
    nop(1'b1, 1);
    chk("open", 8'h04, O_BANK_OPEN);
    op(1'b1, 1'b0, 10'h09B, 10'h000);
    nop(1'b1, 1);
    chk("open", 8'h00, O_BANK_OPEN);
    foreach (tbl_r[i])
    begin
      op(1'b1, 1'b0, tbl_r[i], 10'h000);
      chk("cmd", tbl_c[i], O_CMD);
    end
    chk("valid", 1'b0, O_CMD_VALID);
    op(1'b0, 1'b1, 10'h000, 10'h000);
    chk("state", 3'h2, O_POWER_STATE);
    op(1'b0, 1'b0, 10'h000, 10'h000);
    chk("state", 3'h2, O_POWER_STATE);
    op(1'b1, 1'b1, 10'h000, 10'h000);
    chk("state", 3'h0, O_POWER_STATE);
    op(1'b1, 1'b0, 10'h002, 10'h000);
    op(1'b0, 1'b1, 10'h000, 10'h000);
    chk("state", 3'h3, O_POWER_STATE);
    op(1'b1, 1'b1, 10'h000, 10'h000);
    chk("state", 3'h1, O_POWER_STATE);
    op(1'b1, 1'b0, 10'h01B, 10'h000);
    op(1'b0, 1'b0, 10'h004, 10'h000);
    chk("state", 3'h5, O_POWER_STATE);
    op(1'b1, 1'b1, 10'h000, 10'h000);
    chk("state", 3'h0, O_POWER_STATE);
    op(1'b0, 1'b0, 10'h003, 10'h000);
    chk("state", 3'h6, O_POWER_STATE);
    op(1'b1, 1'b1, 10'h000, 10'h000);
    chk("state", 3'h7, O_POWER_STATE);
    op(1'b0, 1'b1, 10'h000, 10'h000);
    chk("state", 3'h4, O_POWER_STATE);
    op(1'b1, 1'b1, 10'h000, 10'h000);
    chk("state", 3'h7, O_POWER_STATE);
    op(1'b0, 1'b1, 10'h000, 10'h000);
    @(posedge I_CLK);
    i_init_done <= 1'b1;
    op(1'b1, 1'b1, 10'h000, 10'h000);
    chk("state", 3'h0, O_POWER_STATE);
    // resetting context from outside: idle falls back to resetting
    @(posedge I_CLK);
    i_resetting <= 1'b1;
    i_init_done <= 1'b0;
    nop(1'b1, 1);
    chk("state", 3'h7, O_POWER_STATE);
    i_resetting <= 1'b0;
    i_init_done <= 1'b1;
    nop(1'b1, 1);
    chk("state", 3'h0, O_POWER_STATE);
    report_and_stop();
  end
  // whole run is about 76 cycles; this margin only catches a hang
  initial
  begin
    #20us;
    error_cnt++;
    report_and_stop();
  end
endmodule
bind lcd_cmd_decode lcd_cmd_monitor chk_u (.*);
